// File: design/cgc_regs.sv
// clock generator second control register and status registers
//
// Overview of operation
// - lock-loss flag requests interrupt or reset
// - multiplier N is four plus twice code
// - multiplier write ignored while previous pending
// - clock loss requests interrupt or reset
// - output divider R is two to code
// - divider write ignored while previous pending
// - mode status shows active clock mode
// - reference status shows crystal or external
// - sticky lock-loss flag until software clears
// - lock bit, forced clear outside engaged modes
// - sticky clock-loss flag until software clears
// - external reference stable bit follows qualifier
// - interrupt flag cleared by read then write-one
// - new interrupt restarts the clear sequence
// - writing zero to interrupt flag ignored
// - oscillator stable after two small error changes
// - stable bit gates loop close and monitoring
// - stable bit cleared when generator is off
// - clock-loss detection only when not disabled
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "cgc_cfg.svh"
module cgc_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [`CGC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock generator core, asynchronous levels
  input wire cgc_pkg::cgc_core_status_t core_status,
  // count error samples, same clock
  input wire logic [`CGC_ERR_W-1:0] count_error,
  input wire logic count_error_valid,
  // controls toward the core
  output cgc_pkg::cgc_loop_ctrl_t loop_ctrl,
  output logic loop_ctrl_busy,
  output logic [1:0] mode_select_field,
  output logic clock_loss_detect_disable,
  output logic loop_close_enable,
  output logic dco_monitor_enable,
  // requests
  output logic irq_request,
  output logic reset_request
);

  // ----------------------------------------------------------------
  // synchronised core state
  // ----------------------------------------------------------------
  cgc_pkg::cgc_core_status_t core_sync;

  cgc_sync #(
    .WIDTH($bits(cgc_pkg::cgc_core_status_t))
  ) i_cgc_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(core_status),
    .sync_out(core_sync)
  );

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic lock_loss_reset_select;
  logic clock_loss_reset_select;
  logic [2:0] loop_multiplier_code;
  logic [2:0] output_divider_code;
  logic [`CGC_CNT_W-1:0] mult_busy_cnt;
  logic [`CGC_CNT_W-1:0] div_busy_cnt;
  logic [1:0] mode_status_field;
  logic lock_loss_flag;
  logic clock_loss_flag;
  logic clock_gen_irq_flag;
  logic osc_core_stable;
  logic lock_bit;
  logic locked_prev;
  logic clock_lost_prev;
  logic lock_loss_event;
  logic clock_loss_event;
  logic irq_event;
  logic wr_c2;
  logic wr_s1;
  logic wr_mc;
  logic rd_s1;
  logic clr_lol;
  logic clr_loc;
  logic clr_irq_req;
  logic [`CGC_ERR_W-1:0] prev_error;
  logic [`CGC_ERR_W-1:0] error_delta;
  logic [1:0] small_change_cnt;
  logic have_prev_error;
  logic [7:0] next_rdata;
  cgc_pkg::cgc_clr_state_t clr_state;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_c2 = reg_wr && (reg_addr == `CGC_OFF_CONTROL_TWO);
  assign wr_s1 = reg_wr && (reg_addr == `CGC_OFF_STATUS_ONE);
  assign wr_mc = reg_wr && (reg_addr == `CGC_OFF_MODE_CONFIG);
  assign rd_s1 = reg_rd && (reg_addr == `CGC_OFF_STATUS_ONE);
  // sticky flags clear on a write of one to their bit
  assign clr_lol = wr_s1 && reg_wdata[`CGC_S1_LOL];
  assign clr_loc = wr_s1 && reg_wdata[`CGC_S1_LOC];
  assign clr_irq_req = wr_s1 && reg_wdata[`CGC_S1_IRQ];

  // ----------------------------------------------------------------
  // control two: response selects
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lock_loss_reset_select <= 1'(`CGC_C2_RESET >> `CGC_C2_LOL_RE);
      clock_loss_reset_select <= 1'(`CGC_C2_RESET >> `CGC_C2_LOC_RE);
    end else if (wr_c2) begin
      lock_loss_reset_select <= reg_wdata[`CGC_C2_LOL_RE];
      clock_loss_reset_select <= reg_wdata[`CGC_C2_LOC_RE];
    end
  end

  // ----------------------------------------------------------------
  // control two: multiplier field with apply window
  // ----------------------------------------------------------------
  // the core latches a new factor across its own clock; a second write
  // during that window would tear the value, so it is dropped
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loop_multiplier_code <= 3'h0;
      mult_busy_cnt <= '0;
    end else if (wr_c2 && (mult_busy_cnt == '0)) begin
      loop_multiplier_code <= reg_wdata[`CGC_C2_MFD_HI:`CGC_C2_MFD_LO];
      mult_busy_cnt <= `CGC_CNT_W'(`CGC_APPLY_CYCLES);
    end else if (mult_busy_cnt != '0) begin
      mult_busy_cnt <= mult_busy_cnt - `CGC_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // control two: divider field with apply window
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      output_divider_code <= 3'h0;
      div_busy_cnt <= '0;
    end else if (wr_c2 && (div_busy_cnt == '0)) begin
      output_divider_code <= reg_wdata[`CGC_C2_RFD_HI:`CGC_C2_RFD_LO];
      div_busy_cnt <= `CGC_CNT_W'(`CGC_APPLY_CYCLES);
    end else if (div_busy_cnt != '0) begin
      div_busy_cnt <= div_busy_cnt - `CGC_CNT_W'(1);
    end
  end

  assign loop_ctrl_busy = (mult_busy_cnt != '0) || (div_busy_cnt != '0);

  // ----------------------------------------------------------------
  // factors toward the loop and divider
  // ----------------------------------------------------------------
  // software alone keeps the product within the oscillator range
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      loop_ctrl.multiplier_n <= `CGC_MULT_BASE;
      loop_ctrl.divider_r <= `CGC_DIV_ONE;
    end else begin
      loop_ctrl.multiplier_n <= `CGC_MULT_BASE + {1'b0, loop_multiplier_code, 1'b0};
      loop_ctrl.divider_r <= `CGC_DIV_ONE << output_divider_code;
    end
  end

  // ----------------------------------------------------------------
  // mode configuration
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_select_field <= 2'(`CGC_MC_RESET >> `CGC_MC_SEL_LO);
      clock_loss_detect_disable <= 1'(`CGC_MC_RESET >> `CGC_MC_CLOCK_LOSS_DETECT_DISABLE);
    end else if (wr_mc) begin
      mode_select_field <= reg_wdata[`CGC_MC_SEL_HI:`CGC_MC_SEL_LO];
      clock_loss_detect_disable <= reg_wdata[`CGC_MC_CLOCK_LOSS_DETECT_DISABLE];
    end
  end

  // ----------------------------------------------------------------
  // mode status and lock
  // ----------------------------------------------------------------
  // mode comes from the core's domain, so a new select shows only after
  // the core switches and the synchroniser passes it on
  assign mode_status_field = core_sync.mode;

  // lock reads zero when off, self-clocked or bypassed
  assign lock_bit = core_sync.locked && !core_sync.gen_off
                    && (mode_status_field != `CGC_MODE_SELF)
                    && (mode_status_field != `CGC_MODE_BYPASS);

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      locked_prev <= 1'b0;
      clock_lost_prev <= 1'b0;
    end else begin
      locked_prev <= lock_bit;
      clock_lost_prev <= core_sync.clock_lost;
    end
  end

  // unexpected loss: lock falls while the loop stays engaged
  assign lock_loss_event = locked_prev && !core_sync.locked && !core_sync.gen_off
                           && (mode_status_field != `CGC_MODE_SELF)
                           && (mode_status_field != `CGC_MODE_BYPASS);
  assign clock_loss_event = core_sync.clock_lost && !clock_lost_prev
                            && !clock_loss_detect_disable;

  // ----------------------------------------------------------------
  // sticky loss flags
  // ----------------------------------------------------------------
  // a new event beats a clear in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lock_loss_flag <= 1'b0;
    end else if (lock_loss_event) begin
      lock_loss_flag <= 1'b1;
    end else if (clr_lol) begin
      lock_loss_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clock_loss_flag <= 1'b0;
    end else if (clock_loss_event) begin
      clock_loss_flag <= 1'b1;
    end else if (clr_loc) begin
      clock_loss_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flag and clear sequence
  // ----------------------------------------------------------------
  assign irq_event = (lock_loss_event && !lock_loss_reset_select)
                     || (clock_loss_event && !clock_loss_reset_select);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clr_state <= cgc_pkg::CLR_IDLE;
    end else begin
      unique case (clr_state)
        cgc_pkg::CLR_IDLE: begin
          if (rd_s1 && clock_gen_irq_flag && !irq_event) begin
            clr_state <= cgc_pkg::CLR_ARMED;
          end
        end
        cgc_pkg::CLR_ARMED: begin
          // a fresh interrupt sends software back to the read
          if (irq_event || clr_irq_req) begin
            clr_state <= cgc_pkg::CLR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clock_gen_irq_flag <= 1'b0;
    end else if (irq_event) begin
      clock_gen_irq_flag <= 1'b1;
    end else if (clr_irq_req && (clr_state == cgc_pkg::CLR_ARMED)) begin
      clock_gen_irq_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  // select bits only matter while their flag stands
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= (lock_loss_flag && lock_loss_reset_select)
                       || (clock_loss_flag && clock_loss_reset_select);
    end
  end

  assign irq_request = clock_gen_irq_flag;

  // ----------------------------------------------------------------
  // oscillator stability
  // ----------------------------------------------------------------
  assign error_delta = (count_error >= prev_error) ? (count_error - prev_error)
                                                   : (prev_error - count_error);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prev_error <= '0;
      have_prev_error <= 1'b0;
    end else if (core_sync.gen_off) begin
      have_prev_error <= 1'b0;
    end else if (count_error_valid) begin
      prev_error <= count_error;
      have_prev_error <= 1'b1;
    end
  end

  // counts consecutive small changes, saturating at two
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      small_change_cnt <= 2'h0;
    end else if (core_sync.gen_off || !core_sync.dco_running) begin
      small_change_cnt <= 2'h0;
    end else if (count_error_valid && have_prev_error) begin
      if (error_delta > `CGC_UNLOCK_TOL) begin
        small_change_cnt <= 2'h0;
      end else if (small_change_cnt != `CGC_STABLE_SAMPLES) begin
        small_change_cnt <= small_change_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      osc_core_stable <= 1'b0;
    end else if (core_sync.gen_off) begin
      osc_core_stable <= 1'b0;
    end else begin
      osc_core_stable <= (small_change_cnt == `CGC_STABLE_SAMPLES)
                         && core_sync.dco_running;
    end
  end

  // ----------------------------------------------------------------
  // loop close and monitor gating
  // ----------------------------------------------------------------
  // the core holds self-clocked until this rises after leaving off
  assign loop_close_enable = mode_select_field[0] && osc_core_stable;
  assign dco_monitor_enable = (mode_status_field == `CGC_MODE_SELF)
                              && osc_core_stable;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `CGC_OFF_CONTROL_TWO: begin
        next_rdata[`CGC_C2_LOL_RE] = lock_loss_reset_select;
        next_rdata[`CGC_C2_MFD_HI:`CGC_C2_MFD_LO] = loop_multiplier_code;
        next_rdata[`CGC_C2_LOC_RE] = clock_loss_reset_select;
        next_rdata[`CGC_C2_RFD_HI:`CGC_C2_RFD_LO] = output_divider_code;
      end
      `CGC_OFF_STATUS_ONE: begin
        next_rdata[`CGC_S1_MODE_HI:`CGC_S1_MODE_LO] = mode_status_field;
        next_rdata[`CGC_S1_REF] = core_sync.ref_crystal;
        next_rdata[`CGC_S1_LOL] = lock_loss_flag;
        next_rdata[`CGC_S1_LOCK] = lock_bit;
        next_rdata[`CGC_S1_LOC] = clock_loss_flag;
        next_rdata[`CGC_S1_ERC] = core_sync.ext_ok;
        next_rdata[`CGC_S1_IRQ] = clock_gen_irq_flag;
      end
      `CGC_OFF_STATUS_TWO: begin
        next_rdata[`CGC_S2_DCO] = osc_core_stable;
      end
      `CGC_OFF_MODE_CONFIG: begin
        next_rdata[`CGC_MC_SEL_HI:`CGC_MC_SEL_LO] = mode_select_field;
        next_rdata[`CGC_MC_CLOCK_LOSS_DETECT_DISABLE] = clock_loss_detect_disable;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : cgc_regs

// File: common/cgc_cfg.svh
// constants for the clock generator control and status registers
`ifndef CGC_CFG_SVH
`define CGC_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CGC_ADDR_W 8
`define CGC_OFF_CONTROL_TWO 8'h00
`define CGC_OFF_STATUS_ONE 8'h01
`define CGC_OFF_STATUS_TWO 8'h02
`define CGC_OFF_MODE_CONFIG 8'h03

// ----------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------
`define CGC_C2_LOL_RE 7
`define CGC_C2_MFD_HI 6
`define CGC_C2_MFD_LO 4
`define CGC_C2_LOC_RE 3
`define CGC_C2_RFD_HI 2
`define CGC_C2_RFD_LO 0
`define CGC_C2_RESET 8'h00

// ----------------------------------------------------------------
// status one fields
// ----------------------------------------------------------------
`define CGC_S1_MODE_HI 7
`define CGC_S1_MODE_LO 6
`define CGC_S1_REF 5
`define CGC_S1_LOL 4
`define CGC_S1_LOCK 3
`define CGC_S1_LOC 2
`define CGC_S1_ERC 1
`define CGC_S1_IRQ 0

// ----------------------------------------------------------------
// status two and mode config fields
// ----------------------------------------------------------------
`define CGC_S2_DCO 0
`define CGC_MC_SEL_HI 4
`define CGC_MC_SEL_LO 3
`define CGC_MC_CLOCK_LOSS_DETECT_DISABLE 1
`define CGC_MC_RESET 8'h00

// ----------------------------------------------------------------
// modes, factors and timing
// ----------------------------------------------------------------
`define CGC_MODE_SELF 2'h0
`define CGC_MODE_BYPASS 2'h2
`define CGC_MULT_BASE 5'h04
`define CGC_DIV_ONE 8'h01
`define CGC_APPLY_NS 40
`define CGC_CLK_NS 10
`define CGC_APPLY_CYCLES ((`CGC_APPLY_NS + `CGC_CLK_NS - 1) / `CGC_CLK_NS)
`define CGC_CNT_W 4
`define CGC_ERR_W 12
`define CGC_UNLOCK_TOL 12'h004
`define CGC_STABLE_SAMPLES 2'h2

`endif

// File: common/cgc_pkg.sv
// types shared by the clock generator register block
package cgc_pkg;

  // raw state reported by the clock generator core
  typedef struct packed {
    logic [1:0] mode;
    logic locked;
    logic ext_ok;
    logic ref_crystal;
    logic clock_lost;
    logic dco_running;
    logic gen_off;
  } cgc_core_status_t;

  // factors handed to the loop and divider
  typedef struct packed {
    logic [4:0] multiplier_n;
    logic [7:0] divider_r;
  } cgc_loop_ctrl_t;

  typedef enum logic {
    CLR_IDLE,
    CLR_ARMED
  } cgc_clr_state_t;

endpackage : cgc_pkg

// File: design/cgc_sync.sv
// two flip-flop level synchroniser of parameterised width
`timescale 1ns/10ps
module cgc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // stage_one is read by sync_out only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : cgc_sync

// File: sim/cgc_regs_monitor.sv
// assertion checker for the clock generator register block
`timescale 1ns/10ps
`include "cgc_cfg.svh"
module cgc_regs_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [`CGC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire cgc_pkg::cgc_core_status_t core_status,
  input wire logic [`CGC_ERR_W-1:0] count_error,
  input wire logic count_error_valid,
  input wire cgc_pkg::cgc_loop_ctrl_t loop_ctrl,
  input wire logic loop_ctrl_busy,
  input wire logic [1:0] mode_select_field,
  input wire logic clock_loss_detect_disable,
  input wire logic loop_close_enable,
  input wire logic dco_monitor_enable,
  // requests
  input wire logic irq_request,
  input wire logic reset_request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // four samples let the level pass the synchronisers first
  sequence s_lock_held;
    (core_status.locked && core_status.mode[0] && !core_status.gen_off) [*4];
  endsequence
  sequence s_lock_drop;
    s_lock_held ##1 (!core_status.locked && core_status.mode[0] && !core_status.gen_off);
  endsequence
  sequence s_mult_write;
    reg_wr && reg_addr == `CGC_OFF_CONTROL_TWO;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  mult_range_a: assert property (
    !loop_ctrl.multiplier_n[0] && loop_ctrl.multiplier_n inside {[5'h04:5'h12]})
    else $error("multiplier outside the legal set");
  div_pow_a: assert property ($onehot(loop_ctrl.divider_r))
    else $error("divider not a power of two");
  mult_cause_a: assert property ($changed(loop_ctrl.multiplier_n) |->
    $past(reg_wr && reg_addr == `CGC_OFF_CONTROL_TWO, 2))
    else $error("multiplier changed without a write");
  mult_hold_a: assert property ($changed(loop_ctrl.multiplier_n) |=> $stable(loop_ctrl.multiplier_n) [*4])
    else $error("multiplier write taken inside window");
  div_hold_a: assert property ($changed(loop_ctrl.divider_r) |=> $stable(loop_ctrl.divider_r) [*4])
    else $error("divider write taken inside window");
  busy_span_a: assert property ($rose(loop_ctrl_busy) |-> loop_ctrl_busy [*4])
    else $error("busy window shorter than four cycles");
  busy_start_a: assert property (!loop_ctrl_busy ##0 s_mult_write |=> loop_ctrl_busy)
    else $error("accepted write opened no busy window");
  irq_clear_a: assert property ($fell(irq_request) |->
    $past(reg_wr && reg_addr == `CGC_OFF_STATUS_ONE && reg_wdata[0]))
    else $error("interrupt dropped without a write of one");
  loss_req_a: assert property (
    $rose(core_status.clock_lost) && !clock_loss_detect_disable |-> ##[1:6] (irq_request || reset_request))
    else $error("clock loss raised no request");
  lock_req_a: assert property (s_lock_drop |-> ##[1:6] (irq_request || reset_request))
    else $error("lock loss raised no request");
  close_gate_a: assert property (
    loop_close_enable |-> mode_select_field[0] && !$past(core_status.gen_off, 3))
    else $error("loop closed while select bit is zero or generator off");
  off_clear_a: assert property (
    core_status.gen_off [*4] |-> !loop_close_enable && !dco_monitor_enable)
    else $error("stable gates still open while off");
endmodule : cgc_regs_monitor

bind cgc_regs cgc_regs_monitor i_cgc_regs_monitor (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .core_status(core_status), .count_error(count_error),
  .count_error_valid(count_error_valid), .loop_ctrl(loop_ctrl),
  .loop_ctrl_busy(loop_ctrl_busy), .mode_select_field(mode_select_field),
  .clock_loss_detect_disable(clock_loss_detect_disable),
  .loop_close_enable(loop_close_enable), .dco_monitor_enable(dco_monitor_enable),
  .irq_request(irq_request), .reset_request(reset_request));

// File: sim/cgc_regs_bench.sv
// self-checking bench for the clock generator register block
`timescale 1ns/10ps
`include "cgc_cfg.svh"
module cgc_regs_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [`CGC_ADDR_W-1:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  cgc_pkg::cgc_core_status_t core_status = 8'h00;
  logic [`CGC_ERR_W-1:0] count_error = 12'h000;
  logic count_error_valid = 1'b0;
  cgc_pkg::cgc_loop_ctrl_t loop_ctrl;
  logic loop_ctrl_busy, loop_close_enable, dco_monitor_enable, irq_request, reset_request;
  logic [1:0] mode_select_field;
  logic clock_loss_detect_disable;
  int errors = 0;
  int checks_done = 0;

  always #5 mclk = ~mclk;

  cgc_regs i_cgc_regs (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_status(core_status), .count_error(count_error),
    .count_error_valid(count_error_valid), .loop_ctrl(loop_ctrl),
    .loop_ctrl_busy(loop_ctrl_busy), .mode_select_field(mode_select_field),
    .clock_loss_detect_disable(clock_loss_detect_disable),
    .loop_close_enable(loop_close_enable), .dco_monitor_enable(dco_monitor_enable),
    .irq_request(irq_request), .reset_request(reset_request));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // answer stands one cycle only, so it is taken just after the edge
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk_val({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd_chk
  task set_core(input logic [7:0] v);
    @(posedge mclk);
    core_status <= v;
    cyc(6);
  endtask : set_core
  task loss_event;
    set_core(core_status & 8'hFB);
    set_core(core_status | 8'h04);
  endtask : loss_event
  task sample(input logic [11:0] v);
    @(posedge mclk);
    count_error <= v;
    count_error_valid <= 1'b1;
    @(posedge mclk);
    count_error_valid <= 1'b0;
  endtask : sample

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset_vals;
    chk_val({3'h0, loop_ctrl}, 16'h0401);
    for (int a = 0; a < 4; a++) begin
      rd_chk(8'(a), 8'h00);
    end
    rd_chk(8'h10, 8'h00);
  endtask : t_reset_vals
  task t_factors;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(8'h00, {1'b0, c, 1'b0, c});
      cyc(6);
      chk_val({3'h0, loop_ctrl}, {3'h0, 5'h04 + {1'b0, c, 1'b0}, 8'h01 << c});
      rd_chk(8'h00, {1'b0, c, 1'b0, c});
    end
  endtask : t_factors
  // second write lands inside the window, third just after it
  task t_window;
    wr(8'h00, 8'h11);
    wr(8'h00, 8'h33);
    cyc(1);
    chk_val({3'h0, loop_ctrl}, 16'h0602);
    chk_bit(loop_ctrl_busy, 1'b1);
    wr(8'h00, 8'h55);
    cyc(3);
    chk_val({3'h0, loop_ctrl}, 16'h0E20);
  endtask : t_window
  task t_irq_clear;
    loss_event;
    chk_bit(irq_request, 1'b1);
    wr(8'h01, 8'h00);
    cyc(2);
    chk_bit(irq_request, 1'b1);
    wr(8'h01, 8'h01);
    cyc(2);
    chk_bit(irq_request, 1'b1);
    rd_chk(8'h01, 8'h05);
    loss_event;
    wr(8'h01, 8'h01);
    cyc(2);
    chk_bit(irq_request, 1'b1);
    rd_chk(8'h01, 8'h05);
    wr(8'h01, 8'h01);
    cyc(2);
    chk_bit(irq_request, 1'b0);
    rd_chk(8'h01, 8'h04);
    wr(8'h01, 8'h04);
    rd_chk(8'h01, 8'h00);
  endtask : t_irq_clear
  task t_loss_modes;
    wr(8'h00, 8'h08);
    loss_event;
    chk_val({14'h0000, irq_request, reset_request}, 16'h0001);
    wr(8'h01, 8'h04);
    cyc(2);
    chk_bit(reset_request, 1'b0);
    wr(8'h03, 8'h02);
    cyc(2);
    chk_bit(clock_loss_detect_disable, 1'b1);
    loss_event;
    chk_val({14'h0000, irq_request, reset_request}, 16'h0000);
    rd_chk(8'h01, 8'h00);
    wr(8'h03, 8'h00);
  endtask : t_loss_modes
  task t_status;
    wr(8'h00, 8'h00);
    set_core(8'hF8);
    rd_chk(8'h01, 8'hEA);
    set_core(8'hB8);
    rd_chk(8'h01, 8'hA2);
    set_core(8'h60);
    rd_chk(8'h01, 8'h48);
    set_core(8'h40);
    chk_bit(irq_request, 1'b1);
    rd_chk(8'h01, 8'h51);
    cyc(8);
    rd_chk(8'h01, 8'h51);
    wr(8'h01, 8'h11);
    rd_chk(8'h01, 8'h40);
    wr(8'h00, 8'h80);
    set_core(8'h60);
    set_core(8'h40);
    chk_val({14'h0000, irq_request, reset_request}, 16'h0001);
    wr(8'h01, 8'h10);
    wr(8'h00, 8'h00);
  endtask : t_status
  // a change of exactly the tolerance still counts as small
  task t_dco;
    set_core(8'h02);
    sample(12'h100);
    sample(12'h200);
    sample(12'h300);
    cyc(2);
    rd_chk(8'h02, 8'h00);
    sample(12'h304);
    sample(12'h308);
    cyc(2);
    rd_chk(8'h02, 8'h01);
    chk_val({14'h0000, loop_close_enable, dco_monitor_enable}, 16'h0001);
    wr(8'h03, 8'h08);
    cyc(2);
    chk_val({14'h0000, mode_select_field}, 16'h0001);
    chk_bit(loop_close_enable, 1'b1);
    set_core(8'h03);
    rd_chk(8'h02, 8'h00);
    chk_bit(loop_close_enable, 1'b0);
  endtask : t_dco

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    cyc(1);
    t_reset_vals;
    t_factors;
    t_window;
    t_irq_clear;
    t_loss_modes;
    t_status;
    t_dco;
    final_report;
  end
endmodule : cgc_regs_bench
